// ---- src/tan_pkg.sv ----
// Package: addresses, field positions, reset values, states and carriers of the register slice
`default_nettype none
package tan_pkg;
    // Management frame fields
    localparam logic [4:0] DEVICE_ADDR = 5'h07;
    localparam logic [1:0] START_CODE = 2'h0;
    localparam logic [1:0] OP_ADDRESS = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [1:0] OP_READ_INC = 2'h2;
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] HEADER_LAST = 6'h0d;
    localparam logic [5:0] DATA_LAST = 6'h0f;

    // Register addresses
    localparam logic [15:0] ADDR_PARTNER_NP_LOW = 16'h020b;
    localparam logic [15:0] ADDR_PARTNER_NP_TOP = 16'h020d;
    localparam logic [15:0] ADDR_ADVERT_CTRL = 16'h020e;
    localparam logic [15:0] ADDR_PARTNER_STATUS = 16'h020f;
    localparam logic [15:0] ADDR_FORCED_CTRL = 16'h8000;
    localparam logic [15:0] ADDR_EXTRA_STATUS = 16'h8001;

    // Field positions
    localparam int ADV_LONG_BIT = 15;
    localparam int ADV_EEE_BIT = 14;
    localparam int ADV_HI_ABL_BIT = 13;
    localparam int ADV_HI_REQ_BIT = 12;
    localparam int PS_LONG_BIT = 15;
    localparam int PS_EEE_BIT = 14;
    localparam int PS_HI_ABL_BIT = 13;
    localparam int PS_HI_REQ_BIT = 12;
    localparam int PS_SHORT_FD_BIT = 7;
    localparam int PS_SHORT_HD_BIT = 6;
    localparam int FORCED_BIT = 0;
    localparam int NP_SEEN_BIT = 10;
    localparam int INC_LINK_BIT = 9;
    localparam int LEVEL_MSB = 8;
    localparam int LEVEL_LSB = 7;

    // Reset values
    localparam logic [15:0] RESET_NP_TOP = 16'h0000;
    localparam logic RESET_ADV_LONG = 1'b1;
    localparam logic RESET_FORCED = 1'b0;
    localparam logic [1:0] LEVEL_NOT_RUN = 2'h0;
    localparam logic [1:0] LEVEL_LOW = 2'h2;
    localparam logic [1:0] LEVEL_HIGH = 2'h3;

    typedef enum logic [3:0] {
        ST_PREAMBLE = 4'b0001,
        ST_HEADER = 4'b0010,
        ST_TURN = 4'b0100,
        ST_DATA = 4'b1000
    } tan_state_type;

    typedef struct packed {
        logic long_reach;
        logic high_ability;
        logic high_request;
    } tan_adv_bits_type;

    typedef struct packed {
        logic long_reach;
        logic energy_eff;
        logic high_ability;
        logic high_request;
        logic short_full_duplex;
        logic short_half_duplex;
    } tan_partner_ability_type;
endpackage : tan_pkg
`default_nettype wire

// ---- src/tan_regs.sv ----
// Autonegotiation ability and status register slice with its management serial port
// Overview of operation
// RULE1: Partner next page top word is a read-only 16-bit field, reset zero.
// RULE2: Top word reads return the value captured at the last low word read.
// RULE3: Advertised long-reach bit 15 aliases the base-page bit, resets to one, writable.
// RULE4: Advertised energy efficient bit 14 always reads zero.
// RULE5: Bit 13 is a writable alias of high level ability, reset from strap pin.
// RULE6: Bit 12 is a writable alias of high level request, reset from strap pin.
// RULE7: Advertisement register resets to 0x8000 besides strap bits; bits 11..0 read-only.
// RULE8: Partner status bit 15 mirrors partner long-reach ability.
// RULE9: Partner status bit 14 mirrors partner energy efficient ability.
// RULE10: Partner status bits 13 and 12 mirror partner high level ability and request.
// RULE11: Partner short-reach full duplex at bit 7, half duplex at bit 6 mirrored.
// RULE12: Partner status resets to zero; bits 11..8 and 5..0 reserved. The code mirrors partner_ability directly, with no reset.
// RULE13: Forced mode active only with negotiation disabled and forced enable set.
// RULE14: Forced enable is writable bit 0, reset zero, bits 15..1 read-only.
// RULE15: Bit 10 latches high on partner next page request until read.
// RULE16: Bit 9 shows incompatible link, taken on entering good check.
// RULE17: Bits 8..7 show the resolved transmit level outcome.
// RULE18: Level code 0 not run, 2 low level, 3 high level.
// RULE19: Extra status resets to zero; bits 15..11 reserved.
// RULE20: Each aliased bit has one storage element shared by both addresses.
// RULE21: Reserved bits read zero and ignore writes; host writes zero there.
`default_nettype none
module tan_regs #(
    parameter logic [4:0] PORT_ADDR = 5'h00
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_out_en_n,
    input wire logic cfg_high_ability_pin,
    input wire logic cfg_high_request_pin,
    input wire logic negotiation_enable,
    input wire tan_pkg::tan_partner_ability_type partner_ability,
    input wire logic [15:0] partner_np_code_field_two,
    input wire logic partner_next_page_seen,
    input wire logic good_check_entry,
    input wire logic resolution_incompatible,
    input wire logic resolution_high_level,
    input wire logic base_adv_wr,
    input wire tan_pkg::tan_adv_bits_type base_adv_wdata,
    output tan_pkg::tan_adv_bits_type base_adv,
    output logic forced_mode_active
);
    import tan_pkg::*;

    logic mdc_s1, mdc_s2, mdc_s3;
    logic mdio_s1, mdio_s2;
    logic ability_s1, ability_s2, request_s1, request_s2;
    logic rise;
    tan_state_type state;
    logic [5:0] cnt;
    logic [13:0] hdr;
    logic [13:0] next_hdr;
    logic [15:0] shreg;
    logic [15:0] wdata;
    logic [15:0] cur_addr;
    logic [1:0] op_q;
    logic sel_q;
    logic rd_q;
    logic frame_done;
    logic wr_commit;
    logic rd_take;
    logic [15:0] rd_word;
    logic addr_mapped;
    logic [15:0] np_top;
    logic forced_enable;
    logic np_seen;
    logic inc_link;
    logic [1:0] tx_level_resolution;

    // Pin synchronisers
    always_ff @(posedge ref_clk) begin
        mdc_s1 <= mdc;
        mdc_s2 <= mdc_s1;
        mdc_s3 <= mdc_s2;
        mdio_s1 <= mdio_in;
        mdio_s2 <= mdio_s1;
        ability_s1 <= cfg_high_ability_pin;
        ability_s2 <= ability_s1;
        request_s1 <= cfg_high_request_pin;
        request_s2 <= request_s1;
    end

    assign rise = mdc_s2 & ~mdc_s3;
    assign next_hdr = {hdr[12:0], mdio_s2};
    assign wdata = {shreg[14:0], mdio_s2};
    assign frame_done = rise && (state == ST_DATA) && (cnt == DATA_LAST);
    assign wr_commit = frame_done && sel_q && (op_q == OP_WRITE);
    assign rd_take = rise && (state == ST_TURN) && (cnt != 6'h00) && rd_q;

    // Frame engine
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= ST_PREAMBLE;
            cnt <= 6'h00;
            hdr <= 14'h0000;
            shreg <= 16'h0000;
            op_q <= OP_ADDRESS;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
            mdio_out <= 1'b1;
            mdio_out_en_n <= 1'b1;
        end else if (rise) begin
            case (state)
                ST_PREAMBLE: begin
                    if (mdio_s2) begin
                        cnt <= (cnt == PREAMBLE_LEN) ? cnt : cnt + 6'h01;
                    end else if (cnt == PREAMBLE_LEN) begin
                        hdr <= next_hdr;
                        cnt <= 6'h01;
                        state <= ST_HEADER;
                    end else begin
                        cnt <= 6'h00;
                    end
                end
                ST_HEADER: begin
                    hdr <= next_hdr;
                    if (cnt == HEADER_LAST) begin
                        cnt <= 6'h00;
                        if (next_hdr[13:12] == START_CODE && next_hdr[9:5] == PORT_ADDR
                            && next_hdr[4:0] == DEVICE_ADDR) begin
                            op_q <= next_hdr[11:10];
                            sel_q <= 1'b1;
                            rd_q <= next_hdr[11];
                            state <= ST_TURN;
                        end else begin
                            sel_q <= 1'b0;
                            rd_q <= 1'b0;
                            state <= ST_PREAMBLE;
                        end
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
                ST_TURN: begin
                    if (cnt == 6'h00) begin
                        cnt <= 6'h01;
                        if (rd_q && addr_mapped) begin
                            mdio_out <= 1'b0;
                            mdio_out_en_n <= 1'b0;
                        end
                    end else begin
                        cnt <= 6'h00;
                        mdio_out <= rd_word[15];
                        shreg <= {rd_word[14:0], 1'b0};
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    shreg <= wdata;
                    mdio_out <= shreg[15];
                    if (cnt == DATA_LAST) begin
                        cnt <= 6'h00;
                        mdio_out <= 1'b1;
                        mdio_out_en_n <= 1'b1;
                        sel_q <= 1'b0;
                        rd_q <= 1'b0;
                        state <= ST_PREAMBLE;
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
                default: begin
                    state <= ST_PREAMBLE;
                    cnt <= 6'h00;
                end
            endcase
        end
    end

    // Register address pointer
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cur_addr <= 16'h0000;
        end else if (frame_done && sel_q && op_q == OP_ADDRESS) begin
            cur_addr <= wdata;
        end else if (frame_done && sel_q && op_q == OP_READ_INC) begin
            cur_addr <= cur_addr + 16'h0001;
        end
    end

    // Read data selection
    always_comb begin
        rd_word = 16'h0000; // [RULE21]
        addr_mapped = 1'b1;
        if (cur_addr == ADDR_PARTNER_NP_TOP) begin
            rd_word = np_top; // [RULE1] [RULE2]
        end else if (cur_addr == ADDR_ADVERT_CTRL) begin
            rd_word[ADV_LONG_BIT] = base_adv.long_reach; // [RULE3] [RULE20]
            rd_word[ADV_EEE_BIT] = 1'b0; // [RULE4]
            rd_word[ADV_HI_ABL_BIT] = base_adv.high_ability; // [RULE5]
            rd_word[ADV_HI_REQ_BIT] = base_adv.high_request; // [RULE6] [RULE7]
        end else if (cur_addr == ADDR_PARTNER_STATUS) begin
            rd_word[PS_LONG_BIT] = partner_ability.long_reach; // [RULE8]
            rd_word[PS_EEE_BIT] = partner_ability.energy_eff; // [RULE9]
            rd_word[PS_HI_ABL_BIT] = partner_ability.high_ability; // [RULE10]
            rd_word[PS_HI_REQ_BIT] = partner_ability.high_request; // [RULE10]
            rd_word[PS_SHORT_FD_BIT] = partner_ability.short_full_duplex; // [RULE11]
            rd_word[PS_SHORT_HD_BIT] = partner_ability.short_half_duplex; // [RULE11] [RULE12]
        end else if (cur_addr == ADDR_FORCED_CTRL) begin
            rd_word[FORCED_BIT] = forced_enable; // [RULE14]
        end else if (cur_addr == ADDR_EXTRA_STATUS) begin
            rd_word[NP_SEEN_BIT] = np_seen; // [RULE15]
            rd_word[INC_LINK_BIT] = inc_link; // [RULE16]
            rd_word[LEVEL_MSB:LEVEL_LSB] = tx_level_resolution; // [RULE17] [RULE19]
        end else begin
            addr_mapped = 1'b0;
        end
    end

    // Partner next page top word, captured on low word reads
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            np_top <= RESET_NP_TOP; // [RULE1]
        end else if (rd_take && cur_addr == ADDR_PARTNER_NP_LOW) begin
            np_top <= partner_np_code_field_two; // [RULE2]
        end
    end

    // Shared storage of the advertised bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            base_adv.long_reach <= RESET_ADV_LONG; // [RULE3] [RULE7]
            base_adv.high_ability <= ability_s2; // [RULE5]
            base_adv.high_request <= request_s2; // [RULE6]
        end else if (wr_commit && cur_addr == ADDR_ADVERT_CTRL) begin
            base_adv.long_reach <= wdata[ADV_LONG_BIT]; // [RULE20]
            base_adv.high_ability <= wdata[ADV_HI_ABL_BIT]; // [RULE5]
            base_adv.high_request <= wdata[ADV_HI_REQ_BIT]; // [RULE6] [RULE21]
        end else if (base_adv_wr) begin
            base_adv <= base_adv_wdata; // [RULE20]
        end
    end

    // Forced mode enable and its gating
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            forced_enable <= RESET_FORCED; // [RULE14]
            forced_mode_active <= 1'b0;
        end else begin
            if (wr_commit && cur_addr == ADDR_FORCED_CTRL) begin
                forced_enable <= wdata[FORCED_BIT]; // [RULE14]
            end
            forced_mode_active <= ~negotiation_enable & forced_enable; // [RULE13]
        end
    end

    // Latching next page flag; a new request beats the clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            np_seen <= 1'b0; // [RULE19]
        end else if (partner_next_page_seen) begin
            np_seen <= 1'b1; // [RULE15]
        end else if (rd_take && cur_addr == ADDR_EXTRA_STATUS) begin
            np_seen <= 1'b0; // [RULE15]
        end
    end

    // Resolution results taken on entry to good check
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            inc_link <= 1'b0;
            tx_level_resolution <= LEVEL_NOT_RUN; // [RULE18] [RULE19]
        end else if (good_check_entry) begin
            inc_link <= resolution_incompatible; // [RULE16]
            tx_level_resolution <= resolution_incompatible ? LEVEL_NOT_RUN
                : (resolution_high_level ? LEVEL_HIGH : LEVEL_LOW); // [RULE17] [RULE18]
        end
    end
endmodule : tan_regs
`default_nettype wire

// ---- tb/tan_mdio_host.sv ----
// Management host model driving Clause 45 frames on the serial pins
`default_nettype none
module tan_mdio_host
    import tan_pkg::*;
(
    input wire logic ref_clk,
    input wire logic dut_out,
    input wire logic dut_out_en_n,
    output logic mdc,
    output logic mdio_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_en = 1'b0;
    logic host_bit = 1'b1;
    initial mdc = 1'b0;
    // Pull-up when nobody drives
    assign mdio_line = !dut_out_en_n ? dut_out : (host_en ? host_bit : 1'b1);

    // One frame, clock stands low outside it
    task automatic xfer(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd, output logic drove);
        logic [63:0] fr;
        fr = {32'hffffffff, START_CODE, op, 5'h00, DEVICE_ADDR, 2'h2, wd};
        rd = 16'h0000;
        drove = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            @(posedge ref_clk);
            mdc <= 1'b0;
            host_en <= !(op[1] && i < 18);
            host_bit <= fr[i];
            repeat (7) @(posedge ref_clk);
            @(negedge ref_clk);
            if (i == 16) drove = !mdio_line;
            if (i < 16) rd = {rd[14:0], mdio_line};
            @(posedge ref_clk);
            mdc <= 1'b1;
            repeat (7) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        mdc <= 1'b0;
        host_en <= 1'b0;
    endtask : xfer
endmodule : tan_mdio_host
`default_nettype wire

// ---- tb/tan_regs_checker.sv ----
// Port assertions for the autonegotiation register slice
`default_nettype none
module tan_regs_checker
    import tan_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_out_en_n,
    input wire logic cfg_high_ability_pin,
    input wire logic cfg_high_request_pin,
    input wire logic negotiation_enable,
    input wire tan_pkg::tan_partner_ability_type partner_ability,
    input wire logic [15:0] partner_np_code_field_two,
    input wire logic partner_next_page_seen,
    input wire logic good_check_entry,
    input wire logic resolution_incompatible,
    input wire logic resolution_high_level,
    input wire logic base_adv_wr,
    input wire tan_pkg::tan_adv_bits_type base_adv_wdata,
    input wire tan_pkg::tan_adv_bits_type base_adv,
    input wire logic forced_mode_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_reset_exit;
        $rose(nrst);
    endsequence
    sequence s_turn_start;
        $fell(mdio_out_en_n) ##0 !mdio_out;
    endsequence
    a_forced_an_off: assert property (negotiation_enable |=> !forced_mode_active)
        else $error("forced mode active with negotiation enabled");
    a_forced_rise_cause: assert property ($rose(forced_mode_active) |-> !$past(negotiation_enable))
        else $error("forced mode rose without negotiation disabled");
    a_reset_long_one: assert property (s_reset_exit |-> base_adv.long_reach && !forced_mode_active)
        else $error("reset values of long reach or forced mode wrong");
    a_strap_ability: assert property (s_reset_exit |-> base_adv.high_ability == $past(cfg_high_ability_pin, 3))
        else $error("high ability not taken from strap");
    a_strap_request: assert property (s_reset_exit |-> base_adv.high_request == $past(cfg_high_request_pin, 3))
        else $error("high request not taken from strap");
    a_alias_write: assert property (base_adv_wr && !mdc |=> base_adv == $past(base_adv_wdata))
        else $error("base side write not stored");
    a_alias_hold: assert property (!base_adv_wr && !mdc && !$past(mdc, 4) |=> $stable(base_adv))
        else $error("aliased bits changed without a write");
    a_turn_drive: assert property (s_turn_start |=> !mdio_out_en_n [*8])
        else $error("read answer released too early");
endmodule : tan_regs_checker
`default_nettype wire

// ---- tb/test_tan_regs.sv ----
// Self-checking bench for the autonegotiation register slice
`default_nettype none
module test_tan_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import tan_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic mdc, mdio_in, mdio_out, mdio_out_en_n, forced_mode_active;
    logic cfg_high_ability_pin = 1'b1;
    logic cfg_high_request_pin = 1'b0;
    logic negotiation_enable = 1'b1;
    tan_partner_ability_type partner_ability = '0;
    logic [15:0] partner_np_code_field_two = 16'h0000;
    logic partner_next_page_seen = 1'b0;
    logic good_check_entry = 1'b0;
    logic resolution_incompatible = 1'b0;
    logic resolution_high_level = 1'b0;
    logic base_adv_wr = 1'b0;
    tan_adv_bits_type base_adv_wdata = '0;
    tan_adv_bits_type base_adv;
    int fails = 0;
    int n_checks = 0;
    initial forever #20 ref_clk = ~ref_clk;
    tan_regs i_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdio_out(mdio_out),
        .mdio_out_en_n(mdio_out_en_n),
        .cfg_high_ability_pin(cfg_high_ability_pin),
        .cfg_high_request_pin(cfg_high_request_pin),
        .negotiation_enable(negotiation_enable),
        .partner_ability(partner_ability),
        .partner_np_code_field_two(partner_np_code_field_two),
        .partner_next_page_seen(partner_next_page_seen),
        .good_check_entry(good_check_entry),
        .resolution_incompatible(resolution_incompatible),
        .resolution_high_level(resolution_high_level),
        .base_adv_wr(base_adv_wr),
        .base_adv_wdata(base_adv_wdata),
        .base_adv(base_adv),
        .forced_mode_active(forced_mode_active)
    );
    tan_mdio_host i_host (.ref_clk(ref_clk), .dut_out(mdio_out), .dut_out_en_n(mdio_out_en_n), .mdc(mdc),
        .mdio_line(mdio_in));

    function automatic logic [15:0] exp_adv(input logic [2:0] v);
        return {v[2], 1'b0, v[1:0], 12'h000};
    endfunction : exp_adv
    function automatic logic [15:0] exp_extra(input logic np, input logic inc, input logic hi);
        return {5'h00, np, inc, inc ? LEVEL_NOT_RUN : (hi ? LEVEL_HIGH : LEVEL_LOW), 7'h00};
    endfunction : exp_extra
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic dr;
        i_host.xfer(OP_ADDRESS, a, r, dr);
        i_host.xfer(OP_WRITE, d, r, dr);
    endtask : reg_wr
    // Only the next page low word expects no drive; its caller passes the pulled-up value
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] r;
        logic dr;
        i_host.xfer(OP_ADDRESS, a, r, dr);
        i_host.xfer(OP_READ, 16'h0000, r, dr);
        check($sformatf("reg_%h", a), r, e);
        check($sformatf("drive_%h", a), {15'h0000, dr}, {15'h0000, a != ADDR_PARTNER_NP_LOW});
    endtask : rd_chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        logic [15:0] w;
        logic [2:0] v;
        logic [15:0] r;
        logic dr;
        void'($urandom(1));
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(ADDR_ADVERT_CTRL, exp_adv({1'b1, cfg_high_ability_pin, cfg_high_request_pin}));
        rd_chk(ADDR_PARTNER_STATUS, 16'h0000);
        rd_chk(ADDR_FORCED_CTRL, 16'h0000);
        rd_chk(ADDR_EXTRA_STATUS, 16'h0000);
        rd_chk(ADDR_PARTNER_NP_TOP, RESET_NP_TOP);
        for (int k = 0; k < 4; k++) begin
            partner_ability <= (k == 0) ? 6'h3f : 6'($urandom);
            @(posedge ref_clk);
            rd_chk(ADDR_PARTNER_STATUS, {partner_ability[5:2], 4'h0, partner_ability[1:0], 6'h00});
        end
        for (int k = 0; k < 3; k++) begin
            w = (k == 0) ? 16'hffff : {4'($urandom), 12'h000};
            reg_wr(ADDR_ADVERT_CTRL, w);
            check("base_adv", {13'h0000, base_adv}, {13'h0000, w[15], w[13:12]});
            rd_chk(ADDR_ADVERT_CTRL, exp_adv({w[15], w[13:12]}));
            v = (k == 0) ? 3'h0 : 3'($urandom);
            base_adv_wdata <= v;
            base_adv_wr <= 1'b1;
            @(posedge ref_clk);
            base_adv_wr <= 1'b0;
            rd_chk(ADDR_ADVERT_CTRL, exp_adv(v));
        end
        reg_wr(ADDR_FORCED_CTRL, 16'hfffe);
        rd_chk(ADDR_FORCED_CTRL, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            reg_wr(ADDR_FORCED_CTRL, {15'h0000, k[0]});
            negotiation_enable <= k[1];
            repeat (3) @(posedge ref_clk);
            check("forced_mode_active", {15'h0000, forced_mode_active}, {15'h0000, k[0] & !k[1]});
        end
        rd_chk(ADDR_FORCED_CTRL, 16'h0001);
        w = 16'($urandom);
        partner_np_code_field_two <= w;
        rd_chk(ADDR_PARTNER_NP_LOW, 16'hffff);
        partner_np_code_field_two <= ~w;
        rd_chk(ADDR_PARTNER_NP_TOP, w);
        partner_next_page_seen <= 1'b1;
        @(posedge ref_clk);
        partner_next_page_seen <= 1'b0;
        rd_chk(ADDR_EXTRA_STATUS, 16'h0400);
        rd_chk(ADDR_EXTRA_STATUS, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v = (k < 3) ? 3'(k) : 3'($urandom);
            resolution_incompatible <= (v[1:0] == 2'h0);
            resolution_high_level <= v[0];
            good_check_entry <= 1'b1;
            @(posedge ref_clk);
            good_check_entry <= 1'b0;
            resolution_incompatible <= (v[1:0] != 2'h0);
            resolution_high_level <= !v[0];
            rd_chk(ADDR_EXTRA_STATUS, exp_extra(1'b0, v[1:0] == 2'h0, v[0]));
        end
        // Mid-run reset with the straps flipped, then a post-increment read
        partner_ability <= 6'h3f;
        cfg_high_ability_pin <= 1'b0;
        cfg_high_request_pin <= 1'b1;
        nrst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(ADDR_FORCED_CTRL, 16'h0000);
        i_host.xfer(OP_ADDRESS, ADDR_ADVERT_CTRL, r, dr);
        i_host.xfer(OP_READ_INC, 16'h0000, r, dr);
        check("inc_first", r, 16'h9000);
        i_host.xfer(OP_READ, 16'h0000, r, dr);
        check("inc_next", r, 16'hf0c0);
        tally_and_finish();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule : test_tan_regs

bind tan_regs tan_regs_checker i_chk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_out_en_n(mdio_out_en_n),
    .cfg_high_ability_pin(cfg_high_ability_pin),
    .cfg_high_request_pin(cfg_high_request_pin),
    .negotiation_enable(negotiation_enable),
    .partner_ability(partner_ability),
    .partner_np_code_field_two(partner_np_code_field_two),
    .partner_next_page_seen(partner_next_page_seen),
    .good_check_entry(good_check_entry),
    .resolution_incompatible(resolution_incompatible),
    .resolution_high_level(resolution_high_level),
    .base_adv_wr(base_adv_wr),
    .base_adv_wdata(base_adv_wdata),
    .base_adv(base_adv),
    .forced_mode_active(forced_mode_active)
);
`default_nettype wire
